/* hdl/gpp_defs.svh */
// register offsets, field positions, reset values and timing counts of the pin port
// included by the package and the port; defines only
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

`define GPP_NPINS 8
`define GPP_OFS_DIR 5'h00
`define GPP_OFS_DSET 5'h01
`define GPP_OFS_DCLR 5'h02
`define GPP_OFS_DTGL 5'h03
`define GPP_OFS_OUT 5'h04
`define GPP_OFS_LSET 5'h05
`define GPP_OFS_LCLR 5'h06
`define GPP_OFS_LTGL 5'h07
`define GPP_OFS_IN 5'h08
`define GPP_OFS_FLAGS 5'h09
`define GPP_OFS_CFG0 5'h10
`define GPP_OFS_CFG7 5'h17
`define GPP_MIR_DIR 5'h00
`define GPP_MIR_OUT 5'h01
`define GPP_MIR_IN 5'h02
`define GPP_MIR_FLAGS 5'h03
`define GPP_CFG_INV_BIT 7
`define GPP_CFG_PULL_BIT 3
`define GPP_CFG_SENSE_HI 2
`define GPP_CFG_SENSE_LO 0
`define GPP_RST_BYTE 8'h00
`define GPP_DEAD_CYC 2'h3

`endif

/* hdl/gpp_pkg.sv */
// types shared by the pin port and its surroundings
// assumes gpp_defs.svh is on the include path
`include "gpp_defs.svh"

package gpp_pkg;

  typedef enum logic [2:0] {
    GPP_SENSE_NONE = 3'h0,
    GPP_SENSE_ANY = 3'h1,
    GPP_SENSE_RISE = 3'h2,
    GPP_SENSE_FALL = 3'h3,
    GPP_SENSE_OFF = 3'h4,
    GPP_SENSE_LOW = 3'h5
  } gpp_sense_t;

  // one register access per cycle; mirror selects the bit-access map
  typedef struct packed {
    logic wr;
    logic rd;
    logic mirror;
    logic [4:0] addr;
    logic [7:0] wdata;
  } gpp_acc_t;

  // per-pin takeover by another on-chip peripheral
  typedef struct packed {
    logic [7:0] oe_en;
    logic [7:0] oe;
    logic [7:0] out_en;
    logic [7:0] out;
  } gpp_ovr_t;

  typedef struct packed {
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] pad_pullup;
  } gpp_pad_t;

endpackage : gpp_pkg

/* hdl/gpp_port.sv */
// eight-pin general purpose port: direction, level, per-pin config, pin-change flags
// assumes pad inputs are asynchronous and registers are reached over a native access port
// How it works
// R1: after reset outputs tri-stated, input paths enabled.
// R2: pin n config lives at byte offset 0x10 plus n.
// R3: drive-enable set strobe sets only the written bits.
// R4: level set strobe sets, level clear strobe clears output levels.
// R5: level toggle strobe or a write to input value inverts levels.
// R6: drive-enable clear strobe clears only the written bits.
// R7: input value shows synchronized pin unless sense is input-off.
// R8: drive-enable toggle strobe inverts the written bits.
// R9: polarity flip inverts both driven and read values.
// R10: flipping polarity makes an internal edge seen by sensing and events.
// R11: pull-up enable bit turns the pin pull-up on.
// R12: sense select enables a pin's interrupt and picks its trigger.
// R13: software must not change polarity and sense in the same cycle.
// R14: a held synchronizer may raise its interrupt after input re-enable.
// R15: async pins wake on any sense; others only any-edge or level.
// R16: mirror map writes behave exactly like regular register writes.
// R17: an enabled peripheral overrides pin control; the rest stays port-controlled.
// R18: sense hit sets flag; request stays while an enabled flag is set.
// R19: synced pins need one-cycle pulses and have three dead cycles.
// R20: external source holds the pad until the clock restarts.
// R21: event output equals pin value while input enabled, else zero.
// R22: config ignores sleep; synchronizers stop when the clock stops.
// R23: synchronizers of an input-off pin are not advanced.
// R24: drive enable never disables the input path.
// R25: strobe reads return the register they modify.
// R26: sense codes: none, any, rise, fall, off, low; rest reserved.
// R27: flags clear by writing one; zero leaves them.
`timescale 1ns/1ps
`default_nettype none
`include "gpp_defs.svh"

module gpp_port #(
  // pins with full asynchronous sensing; value arbitrary
  parameter logic [7:0] ASYNC_PINS = 8'h01
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire gpp_pkg::gpp_acc_t acc,
  output logic [7:0] rdata,
  input wire logic [7:0] pad_in,
  input wire gpp_pkg::gpp_ovr_t ovr,
  output gpp_pkg::gpp_pad_t pad,
  output logic [7:0] pin_event,
  output logic port_irq,
  output logic wake_req
);

  logic [7:0] dir;
  logic [7:0] out;
  logic [7:0] cfg [0:7];
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] prev;
  logic [7:0] flags;
  logic [1:0] dead [0:7];
  logic [7:0] next_dir;
  logic [7:0] next_out;
  logic [7:0] next_flags;
  logic [7:0] inv;
  logic [7:0] in_on;
  logic [7:0] src_en;
  logic [7:0] wake_ok;
  logic [7:0] pin_val;
  logic [7:0] in_val;
  logic [7:0] hit;
  logic [7:0] read_val;
  logic w_dir, w_dset, w_dclr, w_dtgl;
  logic w_out, w_oset, w_oclr, w_otgl;
  logic w_in, w_flags;

  function automatic logic gpp_irq_src(input logic [2:0] s);
    gpp_irq_src = (s == gpp_pkg::GPP_SENSE_ANY) || (s == gpp_pkg::GPP_SENSE_RISE) ||
                  (s == gpp_pkg::GPP_SENSE_FALL) || (s == gpp_pkg::GPP_SENSE_LOW);
  endfunction : gpp_irq_src

  function automatic logic [2:0] gpp_sense(input logic [7:0] c);
    gpp_sense = c[`GPP_CFG_SENSE_HI:`GPP_CFG_SENSE_LO];
  endfunction : gpp_sense

  // R16 mirror aliases decode to the same write strobes
  always_comb begin
    w_dir = 1'b0;
    w_dset = 1'b0;
    w_dclr = 1'b0;
    w_dtgl = 1'b0;
    w_out = 1'b0;
    w_oset = 1'b0;
    w_oclr = 1'b0;
    w_otgl = 1'b0;
    w_in = 1'b0;
    w_flags = 1'b0;
    if (acc.wr && acc.mirror) begin
      case (acc.addr)
        `GPP_MIR_DIR: w_dir = 1'b1;
        `GPP_MIR_OUT: w_out = 1'b1;
        `GPP_MIR_IN: w_in = 1'b1;
        `GPP_MIR_FLAGS: w_flags = 1'b1;
        default: w_dir = 1'b0;
      endcase
    end else if (acc.wr) begin
      case (acc.addr)
        `GPP_OFS_DIR: w_dir = 1'b1;
        `GPP_OFS_DSET: w_dset = 1'b1;
        `GPP_OFS_DCLR: w_dclr = 1'b1;
        `GPP_OFS_DTGL: w_dtgl = 1'b1;
        `GPP_OFS_OUT: w_out = 1'b1;
        `GPP_OFS_LSET: w_oset = 1'b1;
        `GPP_OFS_LCLR: w_oclr = 1'b1;
        `GPP_OFS_LTGL: w_otgl = 1'b1;
        `GPP_OFS_IN: w_in = 1'b1;
        `GPP_OFS_FLAGS: w_flags = 1'b1;
        default: w_dir = 1'b0;
      endcase
    end
  end

  always_comb begin
    next_dir = dir;
    if (w_dir) next_dir = acc.wdata;
    // R3 set only written bits
    if (w_dset) next_dir = dir | acc.wdata;
    // R6 clear only written bits
    if (w_dclr) next_dir = dir & ~acc.wdata;
    // R8 toggle direction
    if (w_dtgl) next_dir = dir ^ acc.wdata;
  end

  always_comb begin
    next_out = out;
    if (w_out) next_out = acc.wdata;
    // R4 level set and clear
    if (w_oset) next_out = out | acc.wdata;
    if (w_oclr) next_out = out & ~acc.wdata;
    // R5 toggle via strobe or input value
    if (w_otgl || w_in) next_out = out ^ acc.wdata;
  end

  // R1 drivers off after reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dir <= `GPP_RST_BYTE;
    end else begin
      dir <= next_dir;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out <= `GPP_RST_BYTE;
    end else begin
      out <= next_out;
    end
  end

  // R2 config at 0x10 + n; R22 untouched by sleep
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int n = 0; n < `GPP_NPINS; n++) cfg[n] <= `GPP_RST_BYTE;
    end else if (acc.wr && !acc.mirror && acc.addr >= `GPP_OFS_CFG0 && acc.addr <= `GPP_OFS_CFG7) begin
      cfg[acc.addr[2:0]] <= acc.wdata;
    end
  end

  // R26 decode sense codes per pin
  always_comb begin
    for (int n = 0; n < `GPP_NPINS; n++) begin
      inv[n] = cfg[n][`GPP_CFG_INV_BIT];
      // R24 input path depends on sense only, never on direction
      in_on[n] = gpp_sense(cfg[n]) != gpp_pkg::GPP_SENSE_OFF;
      // R12 per-pin interrupt enable
      src_en[n] = gpp_irq_src(gpp_sense(cfg[n]));
      // R15 only any-edge and level wake a clockless non-async pin
      wake_ok[n] = ASYNC_PINS[n] ? src_en[n] :
                   (gpp_sense(cfg[n]) == gpp_pkg::GPP_SENSE_ANY) ||
                   (gpp_sense(cfg[n]) == gpp_pkg::GPP_SENSE_LOW);
    end
  end

  // R23 input-off pins hold their synchronizer, which costs nothing when gated in silicon
  // R22 the chain simply stops with the main clock
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= `GPP_RST_BYTE;
      sync2 <= `GPP_RST_BYTE;
    end else begin
      for (int n = 0; n < `GPP_NPINS; n++) begin
        sync1[n] <= in_on[n] ? pad_in[n] : sync1[n];
        sync2[n] <= in_on[n] ? sync1[n] : sync2[n];
      end
    end
  end

  // R9 R10 polarity flip applies after sync, so flipping it is an internal edge
  assign pin_val = sync2 ^ inv;
  // R7 input value gated by sense
  assign in_val = pin_val & in_on;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prev <= `GPP_RST_BYTE;
    end else begin
      prev <= pin_val;
    end
  end

  // R14 a held edge survives input-off and fires once the chain runs again
  // R19 a change needs one sampled cycle; dead counter blocks the next three
  always_comb begin
    for (int n = 0; n < `GPP_NPINS; n++) begin
      case (gpp_sense(cfg[n]))
        gpp_pkg::GPP_SENSE_ANY: hit[n] = pin_val[n] ^ prev[n];
        gpp_pkg::GPP_SENSE_RISE: hit[n] = pin_val[n] & ~prev[n];
        gpp_pkg::GPP_SENSE_FALL: hit[n] = ~pin_val[n] & prev[n];
        gpp_pkg::GPP_SENSE_LOW: hit[n] = ~pin_val[n];
        default: hit[n] = 1'b0;
      endcase
      if (dead[n] != 2'h0) hit[n] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int n = 0; n < `GPP_NPINS; n++) dead[n] <= 2'h0;
    end else begin
      for (int n = 0; n < `GPP_NPINS; n++) begin
        if (hit[n]) dead[n] <= `GPP_DEAD_CYC;
        else if (dead[n] != 2'h0) dead[n] <= dead[n] - 2'h1;
      end
    end
  end

  // R27 write one clears; R18 a same-cycle hit wins over the clear
  assign next_flags = (flags & ~(w_flags ? acc.wdata : 8'h00)) | hit;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= `GPP_RST_BYTE;
    end else begin
      flags <= next_flags;
    end
  end

  // R18 request held while an enabled flag stands
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      port_irq <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      port_irq <= |(flags & src_en);
      wake_req <= |(hit & wake_ok);
    end
  end

  // R17 peripheral takes over per aspect; R9 driven value inverted; R11 pull-up
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pad.pad_out <= `GPP_RST_BYTE;
      pad.pad_oe <= `GPP_RST_BYTE;
      pad.pad_pullup <= `GPP_RST_BYTE;
    end else begin
      for (int n = 0; n < `GPP_NPINS; n++) begin
        pad.pad_oe[n] <= ovr.oe_en[n] ? ovr.oe[n] : dir[n];
        pad.pad_out[n] <= (ovr.out_en[n] ? ovr.out[n] : out[n]) ^ inv[n];
        pad.pad_pullup[n] <= cfg[n][`GPP_CFG_PULL_BIT];
      end
    end
  end

  // R21 event output is pin value or zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_event <= `GPP_RST_BYTE;
    end else begin
      pin_event <= in_val;
    end
  end

  // R25 strobe addresses read back the register they modify
  always_comb begin
    read_val = 8'h00;
    if (acc.mirror) begin
      case (acc.addr)
        `GPP_MIR_DIR: read_val = dir;
        `GPP_MIR_OUT: read_val = out;
        `GPP_MIR_IN: read_val = in_val;
        `GPP_MIR_FLAGS: read_val = flags;
        default: read_val = 8'h00;
      endcase
    end else begin
      case (acc.addr)
        `GPP_OFS_DIR, `GPP_OFS_DSET, `GPP_OFS_DCLR, `GPP_OFS_DTGL: read_val = dir;
        `GPP_OFS_OUT, `GPP_OFS_LSET, `GPP_OFS_LCLR, `GPP_OFS_LTGL: read_val = out;
        `GPP_OFS_IN: read_val = in_val;
        `GPP_OFS_FLAGS: read_val = flags;
        // offsets past the last pin config are unmapped and read zero
        default: read_val = (acc.addr >= `GPP_OFS_CFG0 && acc.addr <= `GPP_OFS_CFG7) ? cfg[acc.addr[2:0]] : 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= `GPP_RST_BYTE;
    end else if (acc.rd) begin
      rdata <= read_val;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_drive_enable_set_strobe_only: assert property (w_dset |=> dir == ($past(dir) | $past(acc.wdata))) // R3
    else $error("drive-enable set strobe wrong");
  a_drive_enable_clear_strobe_only: assert property (w_dclr |=> dir == ($past(dir) & ~$past(acc.wdata))) // R6
    else $error("drive-enable clear strobe wrong");
  a_drive_enable_toggle_strobe_flip: assert property (w_dtgl |=> dir == ($past(dir) ^ $past(acc.wdata))) // R8
    else $error("drive-enable toggle strobe wrong");
  a_level_set: assert property (w_oset |=> out == ($past(out) | $past(acc.wdata))) // R4
    else $error("level set strobe wrong");
  a_in_toggle: assert property (w_in |=> out == ($past(out) ^ $past(acc.wdata))) // R5
    else $error("write to input value did not toggle level");
  a_oe_follows_dir: assert property (~ovr.oe_en == 8'hff |=> pad.pad_oe == $past(dir)) // R17
    else $error("drive enable does not follow direction");
  a_out_inverted: assert property (ovr.out_en == 8'h00 |=> pad.pad_out == ($past(out) ^ $past(inv))) // R9
    else $error("driven level not inverted by polarity");
  a_dead_time: assert property (hit[0] |=> !hit[0] [*3]) // R19
    else $error("pin 0 fired inside dead time");
  a_irq_hold: assert property (flags[0] && src_en[0] && !w_flags |=> port_irq) // R18
    else $error("request dropped while flag set");
  a_flag_clear: assert property (w_flags && acc.wdata[0] && !hit[0] |=> !flags[0]) // R27
    else $error("flag not cleared by write one");
  a_strobe_read: assert property (acc.rd && !acc.mirror && acc.addr == `GPP_OFS_DSET |=> rdata == $past(dir)) // R25
    else $error("strobe read not returning direction");
  a_event_zero: assert property (!in_on[0] |=> !pin_event[0]) // R21
    else $error("event output high with input off");

  c_rise_flag: cover property (hit[0] ##1 port_irq);
  c_mirror_dir: cover property (acc.wr && acc.mirror && acc.addr == `GPP_MIR_DIR);
  c_set_vs_clear: cover property (w_flags && |(acc.wdata & hit));
  c_wake: cover property (wake_req);

endmodule : gpp_port
`default_nettype wire

/* tb/gpp_pad_model.sv */
// pad side of the pin port: resolves each pad level back into pad_in
// assumes the bench sets which pads an outside source drives and to what
`timescale 1ns/1ps
`default_nettype none
module gpp_pad_model (
  input wire logic ref_clk,
  input wire gpp_pkg::gpp_pad_t pad,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic [7:0] float_lvl = 8'h55;
  // undriven pads wander each cycle so a stale level never reads as valid
  always @(posedge ref_clk) begin
    float_lvl <= ~float_lvl;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.pad_oe[i]) begin
        pad_in[i] = pad.pad_out[i];
      end else if (ext_en[i]) begin
        pad_in[i] = ext_val[i];
      end else if (pad.pad_pullup[i]) begin
        pad_in[i] = 1'b1;
      end else begin
        pad_in[i] = float_lvl[i];
      end
    end
  end
endmodule : gpp_pad_model
`default_nettype wire

/* tb/gpio_pin_port_tb.sv */
// self-checking bench for the pin port: strobes, config, sensing, events, override
// assumes the pad model closes the loop from pad outputs to pad_in
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_port_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  gpp_pkg::gpp_acc_t acc = '0;
  gpp_pkg::gpp_ovr_t ovr = '0;
  gpp_pkg::gpp_pad_t pad;
  logic [7:0] rdata;
  logic [7:0] pad_in;
  logic [7:0] pin_event;
  logic port_irq;
  logic wake_req;
  logic [7:0] ext_en = 8'h01;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] v;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int wakes = 0;

  gpp_port DUT (.ref_clk(ref_clk), .nrst(nrst), .acc(acc), .rdata(rdata), .pad_in(pad_in), .ovr(ovr),
    .pad(pad), .pin_event(pin_event), .port_irq(port_irq), .wake_req(wake_req));
  gpp_pad_model PADS (.ref_clk(ref_clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  always #20 ref_clk = ~ref_clk;
  // wake pulses last one cycle; count them mid-cycle where they are settled
  always @(negedge ref_clk) begin
    if (wake_req === 1'b1) wakes++;
  end
  // a hang ends the run as a failure
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wr(input logic mir, input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 acc = '{wr: 1'b1, rd: 1'b0, mirror: mir, addr: a, wdata: d};
    @(posedge ref_clk);
    #1 acc = '0;
  endtask : wr

  task automatic rd(input logic mir, input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 acc = '{wr: 1'b0, rd: 1'b1, mirror: mir, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    #1 acc = '0;
    d = rdata;
  endtask : rd

  task automatic t_strobes();
    chk("pad_oe", 8'h00, pad.pad_oe);
    chk("pad_pullup", 8'h00, pad.pad_pullup);
    wr(0, 5'h01, 8'h05);
    wr(0, 5'h02, 8'h01);
    wr(0, 5'h03, 8'h03);
    rd(0, 5'h02, v);
    chk("dir", 8'h07, v);
    wr(1, 5'h00, 8'h16);
    rd(0, 5'h00, v);
    chk("dir mirror", 8'h16, v);
    wr(0, 5'h05, 8'hF0);
    wr(0, 5'h06, 8'h30);
    wr(0, 5'h07, 8'h0F);
    wr(0, 5'h08, 8'h01);
    rd(0, 5'h07, v);
    chk("level", 8'hCE, v);
    tick(2);
    chk("pad_oe", 8'h16, pad.pad_oe);
    chk("pad_out", 8'hCE, pad.pad_out);
    rd(0, 5'h08, v);
    chk("input", 8'h06, v & 8'h16);
    $display("test strobes done");
  endtask : t_strobes

  task automatic t_config();
    wr(0, 5'h12, 8'h08);
    wr(0, 5'h11, 8'h80);
    tick(4);
    chk("pad_pullup", 8'h04, pad.pad_pullup);
    chk("pad_out", 8'hCC, pad.pad_out);
    rd(0, 5'h08, v);
    chk("input inv", 8'h06, v & 8'h16);
    wr(0, 5'h11, 8'h00);
    ovr = '{oe_en: 8'h20, oe: 8'h20, out_en: 8'h20, out: 8'h20};
    tick(4);
    chk("pad_oe ovr", 8'h36, pad.pad_oe);
    chk("pad_out ovr", 8'hEE, pad.pad_out);
    ovr = '0;
    $display("test config done");
  endtask : t_config

  task automatic t_sense();
    logic [7:0] hit;
    hit = 8'h2A;
    for (int c = 0; c < 8; c++) begin
      ext_val = 8'h01;
      wr(0, 5'h10, 8'(c));
      tick(8);
      wr(0, 5'h09, 8'hFF);
      tick(8);
      ext_val = 8'h00;
      tick(8);
      rd(0, 5'h09, v);
      chk("flag", {7'h00, hit[c]}, v & 8'h01);
      chk("irq", {7'h00, hit[c]}, {7'h00, port_irq});
    end
    $display("test sense done");
  endtask : t_sense

  task automatic t_clear_event();
    wr(0, 5'h10, 8'h01);
    tick(8);
    wr(0, 5'h09, 8'hFF);
    ext_val = 8'h01;
    tick(8);
    wr(0, 5'h09, 8'h00);
    rd(0, 5'h09, v);
    chk("flag kept", 8'h01, v & 8'h01);
    wr(1, 5'h03, 8'h01);
    tick(2);
    rd(0, 5'h09, v);
    chk("flag clr", 8'h00, v & 8'h01);
    chk("irq clr", 8'h00, {7'h00, port_irq});
    wr(0, 5'h10, 8'h81);
    tick(8);
    rd(0, 5'h09, v);
    chk("flag inv", 8'h01, v & 8'h01);
    wr(0, 5'h10, 8'h00);
    tick(8);
    chk("event", 8'h01, pin_event & 8'h01);
    wr(0, 5'h10, 8'h04);
    tick(8);
    chk("event off", 8'h00, pin_event & 8'h01);
    rd(0, 5'h08, v);
    chk("input off", 8'h00, v & 8'h01);
    $display("test clear and event done");
  endtask : t_clear_event

  // pin 0 is the only fully asynchronous pin; pin 1 loops back from its own driver
  task automatic t_wake();
    int base;
    wr(0, 5'h10, 8'h02);
    wr(0, 5'h11, 8'h02);
    wr(0, 5'h07, 8'h02);
    ext_val = 8'h00;
    tick(8);
    base = wakes;
    wr(0, 5'h07, 8'h02);
    tick(8);
    chk("wake sync rise", 8'h00, 8'(wakes - base));
    ext_val = 8'h01;
    tick(8);
    chk("wake async rise", 8'h01, 8'(wakes - base));
    wr(0, 5'h11, 8'h01);
    wr(0, 5'h07, 8'h02);
    tick(8);
    chk("wake sync any", 8'h02, 8'(wakes - base));
    rd(0, 5'h09, v);
    chk("flags wake", 8'h03, v & 8'h03);
    $display("test wake done");
  endtask : t_wake

  initial begin
    repeat (20) @(posedge ref_clk);
    #1 nrst = 1'b1;
    t_strobes();
    t_config();
    t_sense();
    t_clear_event();
    t_wake();
    complete_run();
  end
endmodule : gpio_pin_port_tb
`default_nettype wire
